// *** logic/flash_seq_pkg.sv ***
`default_nettype none
package flash_seq_pkg;
   // durations in timing_clock_period units, then the block word limit and the counter widths
   localparam int unsigned WORD_PERIODS = 35;
   localparam int unsigned BLOCK_FIRST_PERIODS = 30;
   localparam int unsigned BLOCK_NEXT_PERIODS = 21;
   localparam int unsigned BLOCK_END_PERIODS = 6;
   localparam int unsigned MASS_ERASE_PERIODS = 5297;
   localparam int unsigned SEG_ERASE_PERIODS = 4819;
   localparam int unsigned BLOCK_MAX_NEXT = 63;
   localparam int unsigned CNT_W = 13;
   localparam int unsigned IDX_W = 6;

   typedef enum logic [2:0] {
      OP_WORD,
      OP_BLOCK,
      OP_MASS_ERASE,
      OP_SEG_ERASE
   } op_kind_t;

   typedef struct packed {
      logic start;
      op_kind_t kind;
   } op_req_t;

   typedef struct packed {
      logic busy;
      logic program_pulse;
      logic erase_pulse;
      logic block_end;
      logic done;
   } flash_ctl_t;
endpackage
`default_nettype wire

// *** logic/flash_timing_sequencer.sv ***
// How it works
// RQ1 - a word or byte program holds the array for 35 timing periods.
// RQ2 - the first word of a block program takes 30 timing periods.
// RQ3 - every further word of a block, up to 63 more, takes 21 periods.
// RQ4 - a block program closes with a 6 period wait before done.
// RQ5 - a mass erase lasts 5297 timing periods.
// RQ6 - every duration is a fixed constant counted in timing periods.
// RQ7 - the controller keeps the timing clock between 257 and 476 kHz; the sequencer takes timing_clk as an input and never checks its rate.
// RQ8 - software keeps total programming of a 64-byte block under 4 ms.
// RQ9 - software repeats mass erase until 200 ms total is reached.
// RQ10 - a segment erase lasts a fixed count shorter than mass erase.
`timescale 1ns/1ps
`default_nettype none
module flash_timing_sequencer
   import flash_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic timing_clk,
   input wire op_req_t req,
   input wire logic block_next,
   input wire logic block_last,
   output flash_ctl_t ctl,
   output logic [IDX_W-1:0] block_index
);
   typedef enum logic [2:0] {
      S_IDLE,
      S_WORD,
      S_BLK_FIRST,
      S_BLK_WAIT,
      S_BLK_NEXT,
      S_BLK_END,
      S_MASS,
      S_SEG
   } state_t;

   localparam logic [CNT_W-1:0] C_WORD = CNT_W'(WORD_PERIODS - 1);
   localparam logic [CNT_W-1:0] C_BFIRST = CNT_W'(BLOCK_FIRST_PERIODS - 1);
   localparam logic [CNT_W-1:0] C_BNEXT = CNT_W'(BLOCK_NEXT_PERIODS - 1);
   localparam logic [CNT_W-1:0] C_BEND = CNT_W'(BLOCK_END_PERIODS - 1);
   localparam logic [CNT_W-1:0] C_MASS = CNT_W'(MASS_ERASE_PERIODS - 1);
   localparam logic [CNT_W-1:0] C_SEG = CNT_W'(SEG_ERASE_PERIODS - 1);
   localparam logic [IDX_W-1:0] IDX_MAX = IDX_W'(BLOCK_MAX_NEXT);

   state_t state;
   state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [IDX_W-1:0] next_index;
   logic done;
   logic next_done;
   logic tick;
   logic last_tick;
   logic go_more;
   logic go_end;

   timing_tick u_tick (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .timing_clk(timing_clk),
      .tick(tick)
   );

   // phase ends on the tick that completes its period count
   assign last_tick = tick && (cnt == '0);
   assign go_more = block_next && (block_index != IDX_MAX);
   assign go_end = block_last || (block_next && block_index == IDX_MAX);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_index = block_index;
      next_done = 1'b0;
      case (state)
         S_IDLE: begin
            if (req.start) begin
               case (req.kind)
                  OP_WORD: begin
                     next_state = S_WORD;
                     next_cnt = C_WORD; // see RQ1
                  end
                  OP_BLOCK: begin
                     next_state = S_BLK_FIRST;
                     next_cnt = C_BFIRST; // see RQ2
                     next_index = '0;
                  end
                  OP_MASS_ERASE: begin
                     next_state = S_MASS;
                     next_cnt = C_MASS; // see RQ5
                  end
                  OP_SEG_ERASE: begin
                     next_state = S_SEG;
                     next_cnt = C_SEG; // see RQ10
                  end
                  default: next_state = S_IDLE;
               endcase
            end
         end
         S_WORD, S_MASS, S_SEG: begin
            if (tick) begin
               next_cnt = cnt - 1'b1; // see RQ6
            end
            if (last_tick) begin
               next_state = S_IDLE;
               next_done = 1'b1;
            end
         end
         S_BLK_FIRST, S_BLK_NEXT: begin
            if (tick) begin
               next_cnt = cnt - 1'b1;
            end
            if (last_tick) begin
               next_state = S_BLK_WAIT;
            end
         end
         S_BLK_WAIT: begin
            if (go_end) begin
               next_state = S_BLK_END;
               next_cnt = C_BEND; // see RQ4
            end else if (go_more) begin
               next_state = S_BLK_NEXT;
               next_cnt = C_BNEXT; // see RQ3
               next_index = block_index + 1'b1;
            end
         end
         S_BLK_END: begin
            if (tick) begin
               next_cnt = cnt - 1'b1;
            end
            if (last_tick) begin
               next_state = S_IDLE;
               next_done = 1'b1; // see RQ4
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         cnt <= '0;
         block_index <= '0;
         done <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         block_index <= next_index;
         done <= next_done;
      end
   end

   assign ctl.busy = (state != S_IDLE);
   assign ctl.program_pulse = (state == S_WORD) || (state == S_BLK_FIRST) ||
                              (state == S_BLK_NEXT);
   assign ctl.erase_pulse = (state == S_MASS) || (state == S_SEG);
   assign ctl.block_end = (state == S_BLK_END);
   assign ctl.done = done;

   // tick counter over one phase, for checking
   logic [CNT_W-1:0] ticks_in_phase;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks_in_phase <= '0;
      end else if (state != next_state || state == S_IDLE) begin
         ticks_in_phase <= '0;
      end else if (tick) begin
         ticks_in_phase <= ticks_in_phase + 1'b1;
      end
   end

   property p_word_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_WORD && next_state == S_IDLE) |->
         (ticks_in_phase == C_WORD);
   endproperty
   a_word_len: assert property (p_word_len) // see RQ1
      else $error("word program length wrong");

   property p_bfirst_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_BLK_FIRST && next_state == S_BLK_WAIT) |->
         (ticks_in_phase == C_BFIRST);
   endproperty
   a_bfirst_len: assert property (p_bfirst_len) // see RQ2
      else $error("block first word length wrong");

   property p_bnext_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_BLK_NEXT && next_state == S_BLK_WAIT) |->
         (ticks_in_phase == C_BNEXT);
   endproperty
   a_bnext_len: assert property (p_bnext_len) // see RQ3
      else $error("block next word length wrong");

   property p_bend_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_BLK_END && next_state == S_IDLE) |->
         (ticks_in_phase == C_BEND) ##1 done;
   endproperty
   a_bend_len: assert property (p_bend_len) // see RQ4
      else $error("block end wait wrong");

   property p_mass_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_MASS && next_state == S_IDLE) |->
         (ticks_in_phase == C_MASS);
   endproperty
   a_mass_len: assert property (p_mass_len) // see RQ5
      else $error("mass erase length wrong");

   property p_seg_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_SEG && next_state == S_IDLE) |->
         (ticks_in_phase == C_SEG) && (C_SEG < C_MASS);
   endproperty
   a_seg_len: assert property (p_seg_len) // see RQ10
      else $error("segment erase length wrong");

   property p_count_only_on_tick;
      @(posedge sys_clk) disable iff (!rst_n)
      (state != S_IDLE && state != S_BLK_WAIT && !tick &&
       state == next_state) |=> $stable(cnt);
   endproperty
   a_count_only_on_tick: assert property (p_count_only_on_tick) // see RQ6
      else $error("counter moved without timing tick");

   property p_index_limit;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == S_BLK_WAIT && block_index == IDX_MAX && block_next) |=>
         (state == S_BLK_END);
   endproperty
   a_index_limit: assert property (p_index_limit) // see RQ3
      else $error("block ran past its last word");

   property p_done_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) // see RQ6
      else $error("done longer than one cycle");

   c_word: cover property (@(posedge sys_clk) disable iff (!rst_n)
      state == S_WORD ##1 state == S_IDLE);
   c_block_next: cover property (@(posedge sys_clk) disable iff (!rst_n)
      state == S_BLK_NEXT);
   c_block_end: cover property (@(posedge sys_clk) disable iff (!rst_n)
      state == S_BLK_END ##1 state == S_IDLE);
   c_seg: cover property (@(posedge sys_clk) disable iff (!rst_n)
      state == S_SEG ##1 state == S_IDLE);
endmodule
`default_nettype wire

// *** logic/ftg_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
// makes one-cycle ticks from the timing generator clock level
module timing_tick (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic timing_clk,
   output logic tick
);
   logic sync_first;
   logic sync_second;
   logic sync_third;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_first <= 1'b0;
         sync_second <= 1'b0;
         sync_third <= 1'b0;
      end else begin
         sync_first <= timing_clk;
         sync_second <= sync_first;
         sync_third <= sync_second;
      end
   end

   assign tick = sync_second & ~sync_third;
endmodule
`default_nettype wire

// *** sim/flash_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// array side: counts programmed words, flags program and erase together
module flash_array_model
   import flash_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire flash_ctl_t ctl,
   output int words,
   output logic clash
);
   logic prog_before;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_before <= 1'b0;
         words <= 0;
         clash <= 1'b0;
      end else begin
         prog_before <= ctl.program_pulse;
         if (ctl.program_pulse && !prog_before) words <= words + 1;
         if (ctl.program_pulse && ctl.erase_pulse) clash <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import flash_seq_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic timing_clk = 1'b0;
   // half periods in sys_clk cycles; 86 cycles is 465 kHz at 40 MHz
   localparam int REAL_HALF = 43;
   // fast rate shortens the long runs and the word run after reset
   localparam int FAST_HALF = 2;
   op_req_t req = '0;
   logic block_next = 1'b0;
   logic block_last = 1'b0;
   flash_ctl_t ctl;
   logic [IDX_W-1:0] block_index;
   int words;
   logic clash;
   int dones = 0;
   int miscompares = 0;
   int samples_checked = 0;
   int n;
   int w0;
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (ctl.done === 1'b1) dones <= dones + 1;
   flash_timing_sequencer i_flash_timing_sequencer(.sys_clk(sys_clk),
      .rst_n(rst_n), .timing_clk(timing_clk), .req(req),
      .block_next(block_next), .block_last(block_last), .ctl(ctl),
      .block_index(block_index));
   flash_array_model i_flash_array_model(.sys_clk(sys_clk), .rst_n(rst_n),
      .ctl(ctl), .words(words), .clash(clash));
   task automatic finish_test();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // timing clock with given half period; stands still between calls
   task automatic tick_until(input bit want_done, input int half,
                             output int cnt);
      int d0;
      d0 = dones;
      cnt = 0;
      while (cnt < 6000 && (want_done ? dones == d0
                            : ctl.program_pulse !== 1'b0)) begin
         timing_clk = 1'b1;
         repeat (half) @(negedge sys_clk);
         timing_clk = 1'b0;
         repeat (half) @(negedge sys_clk);
         cnt++;
      end
   endtask
   task automatic start(input op_kind_t k);
      req.kind = k;
      req.start = 1'b1;
      @(negedge sys_clk);
      req.start = 1'b0;
      @(negedge sys_clk);
      check(ctl.busy === 1'b1, "busy after start");
   endtask
   task automatic pulse(input bit nxt, input bit last);
      block_next = nxt;
      block_last = last;
      @(negedge sys_clk);
      block_next = 1'b0;
      block_last = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic test_word();
      start(OP_WORD);
      req.kind = OP_MASS_ERASE;
      req.start = 1'b1;
      @(negedge sys_clk);
      req.start = 1'b0;
      check(ctl.erase_pulse === 1'b0, "start taken while busy");
      tick_until(1'b1, REAL_HALF, n);
      check(n == 35, "word length");
      check(ctl.busy === 1'b0, "busy after word");
   endtask
   task automatic test_bad_kind();
      req.kind = op_kind_t'(3'h5);
      req.start = 1'b1;
      @(negedge sys_clk);
      req.start = 1'b0;
      @(negedge sys_clk);
      check(ctl.busy === 1'b0, "unknown kind started");
   endtask
   task automatic test_block();
      realtime t0;
      t0 = $realtime;
      w0 = words;
      start(OP_BLOCK);
      tick_until(1'b0, FAST_HALF, n);
      check(n == 30 && block_index === '0, "first word");
      for (int i = 1; i <= 63; i++) begin
         pulse(1'b1, 1'b0);
         tick_until(1'b0, FAST_HALF, n);
         check(n == 21 && block_index === i[IDX_W-1:0], "next");
      end
      pulse(1'b1, 1'b0);
      check(ctl.block_end === 1'b1, "next at last index");
      tick_until(1'b1, FAST_HALF, n);
      check(n == 6, "end wait");
      check(words - w0 == 64, "words written");
      check($realtime - t0 < 4.0e6, "block over 4 ms");
   endtask
   task automatic test_block_last();
      start(OP_BLOCK);
      tick_until(1'b0, REAL_HALF, n);
      pulse(1'b1, 1'b1);
      check(ctl.block_end === 1'b1, "last over next");
      check(ctl.program_pulse === 1'b0, "no program in end wait");
      tick_until(1'b1, REAL_HALF, n);
      check(n == 6, "end wait after last");
   endtask
   task automatic test_erase(input op_kind_t k, input int len);
      start(k);
      check(ctl.erase_pulse === 1'b1, "erase phase");
      tick_until(1'b1, FAST_HALF, n);
      check(n == len, "erase length");
   endtask
   task automatic test_reset_mid();
      start(OP_MASS_ERASE);
      rst_n = 1'b0;
      @(negedge sys_clk);
      check(ctl === '0 && block_index === '0, "mid-run reset");
      rst_n = 1'b1;
      start(OP_WORD);
      tick_until(1'b1, FAST_HALF, n);
      check(n == 35, "word after reset");
   endtask
   initial begin
      repeat (90000) @(posedge sys_clk);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (16) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      check(ctl === '0 && block_index === '0, "reset values");
      test_word();
      test_bad_kind();
      test_block();
      test_block_last();
      test_erase(OP_MASS_ERASE, 5297);
      // repeat taken back to back; a full 200 ms is beyond the run
      test_erase(OP_MASS_ERASE, 5297);
      test_erase(OP_SEG_ERASE, SEG_ERASE_PERIODS);
      check(SEG_ERASE_PERIODS < 5297, "segment shorter");
      check(clash === 1'b0, "program and erase overlap");
      test_reset_mid();
      finish_test();
   end
endmodule
`default_nettype wire
